// >>> hdl/tpio_chan.sv
// one general register with its pin: output compare or input capture
`timescale 1ns/1ps
module tpio_chan
	import tpio_pkg::*;
#(
	parameter int WIDTH   = 16,
	parameter bit CH1_SRC = 1'b0,
	parameter bit [WIDTH-1:0] GR_RST = '1
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [3:0]       field,
	input  wire logic             field_wr,
	input  wire logic             inhibit,
	input  wire logic [WIDTH-1:0] count,
	input  wire logic             pin_lvl,
	input  wire logic             ch1_tick,
	input  wire logic             gr_wr,
	input  wire logic [WIDTH-1:0] gr_wdata,
	output logic      [WIDTH-1:0] gr_ff,
	output logic                  pin_out_ff,
	output logic                  pin_oe_ff,
	output logic                  cap_ff,
	output logic                  match_ff
);
	tpio_mode_e mode;
	logic       pin_prev_ff;
	logic       eq_ff;
	logic       rise;
	logic       fall;
	logic       cap_evt;
	logic       match;

	// decode of the 4-bit io field; bit 2 picks the channel 1 source only where one exists
	function automatic tpio_mode_e mode_of(input logic [3:0] f, input logic inh);
		if (inh)
			return TPIO_OFF;
		if (!f[3])
			return (f[1:0] == 2'h0) ? TPIO_OFF : TPIO_OC;
		if (f[2] && CH1_SRC)
			return TPIO_IC_CH1;
		return TPIO_IC_PIN;
	endfunction : mode_of

	assign mode  = mode_of(field, inhibit);
	assign rise  = pin_lvl & ~pin_prev_ff;
	assign fall  = ~pin_lvl & pin_prev_ff;
	assign match = (mode == TPIO_OC) && (count == gr_ff) && !eq_ff;

	always_comb begin
		unique case (mode)
			TPIO_IC_PIN: cap_evt = field[1] ? (rise | fall) : (field[0] ? fall : rise);
			TPIO_IC_CH1: cap_evt = ch1_tick;
			default:     cap_evt = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_prev_ff <= 1'b0;
			eq_ff       <= 1'b0;
		end else begin
			pin_prev_ff <= pin_lvl;
			eq_ff       <= (count == gr_ff);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			gr_ff <= GR_RST;
		else if (cap_evt)
			gr_ff <= count;
		else if (gr_wr)
			gr_ff <= gr_wdata;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_out_ff <= 1'b0;
			pin_oe_ff  <= 1'b0;
		end else begin
			pin_oe_ff <= (mode == TPIO_OC);
			if (field_wr && mode == TPIO_OC)
				pin_out_ff <= field[2];
			else if (match) begin
				unique case (field[1:0])
					2'h1:    pin_out_ff <= 1'b0;
					2'h2:    pin_out_ff <= 1'b1;
					default: pin_out_ff <= ~pin_out_ff;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cap_ff   <= 1'b0;
			match_ff <= 1'b0;
		end else begin
			cap_ff   <= cap_evt;
			match_ff <= match;
		end
	end

	a_cap_loads_count: assert property (@(posedge clk) disable iff (!nrst)
		cap_evt |=> (gr_ff == $past(count)))
		else $error("capture did not load the counter");

	a_toggle_on_match: assert property (@(posedge clk) disable iff (!nrst)
		(match && field[1:0] == 2'h3 && !field_wr) |=> (pin_out_ff != $past(pin_out_ff)))
		else $error("toggle match did not invert the pin");

	a_set_on_match: assert property (@(posedge clk) disable iff (!nrst)
		(match && field[1:0] == 2'h2 && !field_wr) |=> pin_out_ff)
		else $error("set match did not drive one");

	a_clear_on_match: assert property (@(posedge clk) disable iff (!nrst)
		(match && field[1:0] == 2'h1 && !field_wr) |=> !pin_out_ff)
		else $error("clear match did not drive zero");

	a_fall_capture: assert property (@(posedge clk) disable iff (!nrst)
		(mode == TPIO_IC_PIN && field[1:0] == 2'h1 && $fell(pin_lvl)) |=> cap_ff)
		else $error("falling edge not captured");

	a_both_edges: assert property (@(posedge clk) disable iff (!nrst)
		(mode == TPIO_IC_PIN && field[1] && $changed(pin_lvl)) |=> cap_ff)
		else $error("edge not captured in both-edge mode");
endmodule : tpio_chan

// >>> hdl/tpio_pkg.sv
// types shared by the timer pin io control block
package tpio_pkg;
	typedef enum logic [1:0] {
		TPIO_OFF,
		TPIO_OC,
		TPIO_IC_PIN,
		TPIO_IC_CH1
	} tpio_mode_e;
	typedef logic [1:0] tpio_resp_t;
endpackage : tpio_pkg

// >>> hdl/tpio_regs.svh
// register offsets, field positions, reset values for the timer pin io control block
`ifndef TPIO_REGS_SVH
`define TPIO_REGS_SVH

`define TPIO_ADDR_W          8
`define TPIO_OFS_CH5_IOCTL   8'h00
`define TPIO_OFS_CH0_IOCTL_H 8'h04
`define TPIO_OFS_CH0_IOCTL_L 8'h08
`define TPIO_OFS_CH0_MODE    8'h0c
`define TPIO_OFS_CH5_GR_B    8'h10
`define TPIO_OFS_CH0_GR_A    8'h14
`define TPIO_OFS_CH0_GR_C    8'h18
`define TPIO_OFS_STATUS      8'h1c

`define TPIO_CH5_FIELD_LSB   4
`define TPIO_CH0_FIELD_LSB   0
`define TPIO_BUF_A_BIT       0

`define TPIO_IOCTL_RST       8'h00
`define TPIO_MODE_RST        8'h00
`define TPIO_GR_RST          16'hffff

`define TPIO_RESP_OKAY       2'h0
`define TPIO_RESP_SLVERR     2'h2

`define TPIO_SYNC_STAGES     3

`endif

// >>> hdl/tpio_top.sv
// timer pin io control: axi4-lite registers, pin synchronisers, three channel slices
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "tpio_regs.svh"
module tpio_top
	import tpio_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input  wire logic                     clk,
	input  wire logic                     nrst,
	input  wire logic [`TPIO_ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output tpio_pkg::tpio_resp_t          s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [`TPIO_ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output tpio_pkg::tpio_resp_t          s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	input  wire logic [WIDTH-1:0]         ch0_count,
	input  wire logic [WIDTH-1:0]         ch5_count,
	input  wire logic                     ch1_count_up,
	input  wire logic                     ch1_count_down,
	input  wire logic                     ch5_pin_b_in,
	output logic                          ch5_pin_b_out,
	output logic                          ch5_pin_b_oe,
	input  wire logic                     ch0_pin_a_in,
	output logic                          ch0_pin_a_out,
	output logic                          ch0_pin_a_oe,
	input  wire logic                     ch0_pin_c_in,
	output logic                          ch0_pin_c_out,
	output logic                          ch0_pin_c_oe
);
	import tpio_pkg::*;

	localparam int NCH = 3;
	localparam int SB5 = 0;
	localparam int SA0 = 1;
	localparam int SC0 = 2;

	logic [`TPIO_ADDR_W-1:0] aw_addr_ff;
	logic                    aw_full_ff;
	logic [31:0]             w_data_ff;
	logic [3:0]              w_strb_ff;
	logic                    w_full_ff;
	logic                    wr_go;
	logic                    wr_hit;

	logic [7:0]              ch5_io_control_ff;
	logic [7:0]              ch0_io_control_high_ff;
	logic [7:0]              ch0_io_control_low_ff;
	logic [7:0]              ch0_mode_register_ff;
	logic [NCH-1:0]          field_wr_ff;

	logic [NCH-1:0]          pin_raw;
	logic [NCH-1:0]          pin_lvl_ff;
	logic [`TPIO_SYNC_STAGES-1:0] sync_ff [NCH];

	logic [3:0]              field      [NCH];
	logic [WIDTH-1:0]        count      [NCH];
	logic [WIDTH-1:0]        gr         [NCH];
	logic [NCH-1:0]          gr_wr;
	logic [WIDTH-1:0]        gr_wdata   [NCH];
	logic [NCH-1:0]          pin_out;
	logic [NCH-1:0]          pin_oe;
	logic [NCH-1:0]          cap;
	logic [NCH-1:0]          match;
	logic [NCH-1:0]          inhibit;
	logic                    ch1_tick;
	logic                    buffer_mode_a;
	logic [NCH-1:0]          cap_seen_ff;
	logic [NCH-1:0]          match_seen_ff;

	// byte-lane merge of a write into an old register value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction : merge

	// register decode shared by read and write paths
	function automatic logic is_mapped(input logic [`TPIO_ADDR_W-1:0] a);
		unique case (a)
			`TPIO_OFS_CH5_IOCTL, `TPIO_OFS_CH0_IOCTL_H, `TPIO_OFS_CH0_IOCTL_L,
			`TPIO_OFS_CH0_MODE, `TPIO_OFS_CH5_GR_B, `TPIO_OFS_CH0_GR_A,
			`TPIO_OFS_CH0_GR_C, `TPIO_OFS_STATUS:
				return 1'b1;
			default:
				return 1'b0;
		endcase
	endfunction : is_mapped

	// write address and data channels, taken in either order
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_full_ff    <= 1'b0;
			aw_addr_ff    <= '0;
			s_axi_awready <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_ff    <= 1'b1;
			aw_addr_ff    <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end else if (wr_go) begin
			aw_full_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			w_full_ff    <= 1'b0;
			w_data_ff    <= '0;
			w_strb_ff    <= '0;
			s_axi_wready <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_ff    <= 1'b1;
			w_data_ff    <= s_axi_wdata;
			w_strb_ff    <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end else if (wr_go) begin
			w_full_ff <= 1'b0;
		end
	end

	assign wr_go  = aw_full_ff && w_full_ff && !s_axi_bvalid;
	assign wr_hit = wr_go && is_mapped(aw_addr_ff) && aw_addr_ff != `TPIO_OFS_STATUS;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `TPIO_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? `TPIO_RESP_OKAY : `TPIO_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// io control and mode registers; only the documented nibble, or bit 0 of the mode register, is writable
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ch5_io_control_ff      <= `TPIO_IOCTL_RST;
			ch0_io_control_high_ff <= `TPIO_IOCTL_RST;
			ch0_io_control_low_ff  <= `TPIO_IOCTL_RST;
			ch0_mode_register_ff   <= `TPIO_MODE_RST;
			field_wr_ff            <= '0;
		end else begin
			field_wr_ff <= '0;
			if (wr_hit && w_strb_ff[0]) begin
				unique case (aw_addr_ff)
					`TPIO_OFS_CH5_IOCTL: begin
						ch5_io_control_ff <= {w_data_ff[7:4], 4'h0};
						field_wr_ff[SB5]  <= 1'b1;
					end
					`TPIO_OFS_CH0_IOCTL_H: begin
						ch0_io_control_high_ff <= {4'h0, w_data_ff[3:0]};
						field_wr_ff[SA0]       <= 1'b1;
					end
					`TPIO_OFS_CH0_IOCTL_L: begin
						ch0_io_control_low_ff <= {4'h0, w_data_ff[3:0]};
						field_wr_ff[SC0]      <= 1'b1;
					end
					`TPIO_OFS_CH0_MODE:
						ch0_mode_register_ff <= {7'h00, w_data_ff[`TPIO_BUF_A_BIT]};
					default: ;
				endcase
			end
		end
	end

	// general register writes from the bus, merged by byte lane
	always_comb begin
		gr_wr = '0;
		for (int i = 0; i < NCH; i++)
			gr_wdata[i] = WIDTH'(merge(32'(gr[i]), w_data_ff, w_strb_ff));
		if (wr_hit) begin
			gr_wr[SB5] = (aw_addr_ff == `TPIO_OFS_CH5_GR_B);
			gr_wr[SA0] = (aw_addr_ff == `TPIO_OFS_CH0_GR_A);
			gr_wr[SC0] = (aw_addr_ff == `TPIO_OFS_CH0_GR_C);
		end
	end

	// read channel: one read at a time, answer one cycle after it is taken
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= `TPIO_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= is_mapped(s_axi_araddr) ? `TPIO_RESP_OKAY : `TPIO_RESP_SLVERR;
			unique case (s_axi_araddr)
				`TPIO_OFS_CH5_IOCTL:   s_axi_rdata <= {24'h000000, ch5_io_control_ff};
				`TPIO_OFS_CH0_IOCTL_H: s_axi_rdata <= {24'h000000, ch0_io_control_high_ff};
				`TPIO_OFS_CH0_IOCTL_L: s_axi_rdata <= {24'h000000, ch0_io_control_low_ff};
				`TPIO_OFS_CH0_MODE:    s_axi_rdata <= {24'h000000, ch0_mode_register_ff};
				`TPIO_OFS_CH5_GR_B:    s_axi_rdata <= 32'(gr[SB5]);
				`TPIO_OFS_CH0_GR_A:    s_axi_rdata <= 32'(gr[SA0]);
				`TPIO_OFS_CH0_GR_C:    s_axi_rdata <= 32'(gr[SC0]);
				`TPIO_OFS_STATUS:      s_axi_rdata <= {18'h00000, match_seen_ff, cap_seen_ff,
					1'b0, pin_oe, 1'b0, pin_lvl_ff};
				default:               s_axi_rdata <= '0;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// sticky event flags for software, set on every event, cleared by a write of the channel's io control
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cap_seen_ff   <= '0;
			match_seen_ff <= '0;
		end else begin
			cap_seen_ff   <= cap | (cap_seen_ff & ~field_wr_ff);
			match_seen_ff <= match | (match_seen_ff & ~field_wr_ff);
		end
	end

	// pin synchronisers: a change counts once stages two and three agree
	assign pin_raw = {ch0_pin_c_in, ch0_pin_a_in, ch5_pin_b_in};
	generate
		for (genvar g = 0; g < NCH; g++) begin : g_sync
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					sync_ff[g]    <= '0;
					pin_lvl_ff[g] <= 1'b0;
				end else begin
					sync_ff[g] <= {sync_ff[g][`TPIO_SYNC_STAGES-2:0], pin_raw[g]};
					if (sync_ff[g][1] == sync_ff[g][2])
						pin_lvl_ff[g] <= sync_ff[g][2];
				end
			end
		end
	endgenerate

	assign buffer_mode_a = ch0_mode_register_ff[`TPIO_BUF_A_BIT];
	assign ch1_tick      = ch1_count_up | ch1_count_down;
	assign field[SB5]    = ch5_io_control_ff[`TPIO_CH5_FIELD_LSB +: 4];
	assign field[SA0]    = ch0_io_control_high_ff[`TPIO_CH0_FIELD_LSB +: 4];
	assign field[SC0]    = ch0_io_control_low_ff[`TPIO_CH0_FIELD_LSB +: 4];
	assign count[SB5]    = ch5_count;
	assign count[SA0]    = ch0_count;
	assign count[SC0]    = ch0_count;
	assign inhibit       = {buffer_mode_a, 2'b00};

	generate
		for (genvar g = 0; g < NCH; g++) begin : g_chan
			tpio_chan #(
				.WIDTH   (WIDTH),
				.CH1_SRC (g != SB5),
				.GR_RST  (WIDTH'(`TPIO_GR_RST))
			) u_chan (
				.clk        (clk),
				.nrst       (nrst),
				.field      (field[g]),
				.field_wr   (field_wr_ff[g]),
				.inhibit    (inhibit[g]),
				.count      (count[g]),
				.pin_lvl    (pin_lvl_ff[g]),
				.ch1_tick   (ch1_tick),
				.gr_wr      (gr_wr[g]),
				.gr_wdata   (gr_wdata[g]),
				.gr_ff      (gr[g]),
				.pin_out_ff (pin_out[g]),
				.pin_oe_ff  (pin_oe[g]),
				.cap_ff     (cap[g]),
				.match_ff   (match[g])
			);
		end
	endgenerate

	assign ch5_pin_b_out = pin_out[SB5];
	assign ch5_pin_b_oe  = pin_oe[SB5];
	assign ch0_pin_a_out = pin_out[SA0];
	assign ch0_pin_a_oe  = pin_oe[SA0];
	assign ch0_pin_c_out = pin_out[SC0];
	assign ch0_pin_c_oe  = pin_oe[SC0];

	a_rise_capture_a0: assert property (@(posedge clk) disable iff (!nrst)
		(field[SA0] == 4'h8 && $rose(pin_lvl_ff[SA0])) |=> cap[SA0])
		else $error("ch0 a did not capture its own pin rise");

	a_ch5_bit2_ignored: assert property (@(posedge clk) disable iff (!nrst)
		(field[SB5] == 4'hc && $rose(pin_lvl_ff[SB5])) |=> cap[SB5])
		else $error("ch5 b capture lost with bit2 set");

	a_ch1_source: assert property (@(posedge clk) disable iff (!nrst)
		(field[SA0][3:2] == 2'h3 && ch1_tick) |=> (cap[SA0] && gr[SA0] == $past(ch0_count)))
		else $error("channel 1 count did not capture into ch0 a");

	a_buffer_c_inert: assert property (@(posedge clk) disable iff (!nrst)
		buffer_mode_a [*2] |=> (!cap[SC0] && !pin_oe[SC0] && !match[SC0]))
		else $error("register c active in buffer mode");

	a_c_oe_compare: assert property (@(posedge clk) disable iff (!nrst)
		(!buffer_mode_a && !field[SC0][3] && field[SC0][1:0] != 2'h0) |=> pin_oe[SC0])
		else $error("ch0 c compare pin not enabled");

	a_init_level: assert property (@(posedge clk) disable iff (!nrst)
		(field_wr_ff[SB5] && field[SB5][3:0] == 4'h6) |=> (ch5_pin_b_out && ch5_pin_b_oe))
		else $error("ch5 b initial level not one");

	a_bresp_hold: assert property (@(posedge clk) disable iff (!nrst)
		(s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
		else $error("write response dropped before taken");

	a_field_nibble: assert property (@(posedge clk) disable iff (!nrst)
		(ch5_io_control_ff[3:0] == 4'h0 && ch0_io_control_high_ff[7:4] == 4'h0))
		else $error("field outside its nibble");
endmodule : tpio_top

// >>> sim/tpio_far.sv
// far side model: channel counter, channel 1 count pulses, external pin drivers
`timescale 1ns/1ps
module tpio_far (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [15:0] cnt_val,
	input  wire logic        cnt_ld,
	input  wire logic        cnt_step,
	input  wire logic        tick_up,
	input  wire logic        tick_dn,
	input  wire logic [2:0]  ext_lvl,
	input  wire logic [2:0]  pin_out,
	input  wire logic [2:0]  pin_oe,
	output logic      [15:0] cnt_ff,
	output logic             up_ff,
	output logic             dn_ff,
	output logic      [2:0]  pin_in
);
	// counter only moves when told, so captured values are known
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= 16'h0000;
		end else if (cnt_ld) begin
			cnt_ff <= cnt_val;
		end else if (cnt_step) begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end
	// one-cycle count pulses of the neighbouring channel
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			up_ff <= 1'b0;
			dn_ff <= 1'b0;
		end else begin
			up_ff <= tick_up;
			dn_ff <= tick_dn;
		end
	end
	// wire level: block drives while enabled, outside driver otherwise
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : tpio_far

// >>> sim/tpio_top_bench.sv
// self-checking bench for the timer pin io control block
`timescale 1ns/1ps
`include "tpio_regs.svh"
module tpio_top_bench;
	import tpio_pkg::*;
	localparam tpio_resp_t OK = `TPIO_RESP_OKAY;
	localparam tpio_resp_t ER = `TPIO_RESP_SLVERR;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	tpio_resp_t  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [15:0] cnt_val = 16'h0;
	logic        cnt_ld = 1'b0, cnt_step = 1'b0, tick_up = 1'b0, tick_dn = 1'b0;
	logic [2:0]  ext_lvl = 3'h0;
	wire  [15:0] cnt;
	wire         ch1_count_up, ch1_count_down, ch5_pin_b_in, ch0_pin_a_in, ch0_pin_c_in;
	logic        ch5_pin_b_out, ch5_pin_b_oe, ch0_pin_a_out, ch0_pin_a_oe;
	logic        ch0_pin_c_out, ch0_pin_c_oe;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          c;

	always #50 clk = ~clk;

	tpio_top #(.WIDTH(16)) u_dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ch0_count(cnt), .ch5_count(cnt),
		.ch1_count_up, .ch1_count_down, .ch5_pin_b_in, .ch5_pin_b_out, .ch5_pin_b_oe,
		.ch0_pin_a_in, .ch0_pin_a_out, .ch0_pin_a_oe, .ch0_pin_c_in, .ch0_pin_c_out,
		.ch0_pin_c_oe);
	tpio_far u_far (.clk, .nrst, .cnt_val, .cnt_ld, .cnt_step, .tick_up, .tick_dn, .ext_lvl,
		.pin_out({ch0_pin_c_out, ch0_pin_a_out, ch5_pin_b_out}),
		.pin_oe({ch0_pin_c_oe, ch0_pin_a_oe, ch5_pin_b_oe}), .cnt_ff(cnt),
		.up_ff(ch1_count_up), .dn_ff(ch1_count_down),
		.pin_in({ch0_pin_c_in, ch0_pin_a_in, ch5_pin_b_in}));

	task automatic end_of_test;
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic chk_bit(input string nm, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit
	task automatic hang;
		chk_bit("handshake", 1'b1, 1'b0);
		end_of_test();
	endtask : hang
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input tpio_resp_t er);
		int i;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		if (i == 40) hang();
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input tpio_resp_t er);
		int i;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		if (i == 40) hang();
		chk("rdata", e, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
	endtask : rd
	task automatic ld(input logic [15:0] v);
		@(posedge clk);
		cnt_ld <= 1'b1;
		cnt_val <= v;
		@(posedge clk);
		cnt_ld <= 1'b0;
	endtask : ld
	// counter steps from 0x00fe onto 0x0100, where the general register under test (b, then a and c) waits
	task automatic hit;
		ld(16'h00fe);
		cnt_step <= 1'b1;
		repeat (2) @(posedge clk);
		cnt_step <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : hit
	function automatic logic [7:0] io_of(input int ch);
		return ch == 0 ? `TPIO_OFS_CH5_IOCTL :
			ch == 1 ? `TPIO_OFS_CH0_IOCTL_H : `TPIO_OFS_CH0_IOCTL_L;
	endfunction : io_of
	function automatic logic [7:0] gr_of(input int ch);
		return ch == 0 ? `TPIO_OFS_CH5_GR_B : ch == 1 ? `TPIO_OFS_CH0_GR_A : `TPIO_OFS_CH0_GR_C;
	endfunction : gr_of
	function automatic logic [31:0] fld(input int ch, input logic [3:0] code);
		return ch == 0 ? {24'h0, code, 4'h0} : {28'h0, code};
	endfunction : fld
	// channel 0 is b5, 1 is a0, 2 is c0; r and f say which pin edge must capture
	task automatic cap(input int ch, input logic [3:0] code, input logic r, input logic f);
		ext_lvl[ch] <= 1'b0;
		repeat (6) @(posedge clk);
		wr(io_of(ch), fld(ch, code), OK);
		wr(gr_of(ch), 32'h0, OK);
		ld(16'h1111);
		ext_lvl[ch] <= 1'b1;
		repeat (8) @(posedge clk);
		rd(gr_of(ch), r ? 32'h1111 : 32'h0, OK);
		ld(16'h2222);
		ext_lvl[ch] <= 1'b0;
		repeat (8) @(posedge clk);
		rd(gr_of(ch), f ? 32'h2222 : (r ? 32'h1111 : 32'h0), OK);
	endtask : cap

	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		rd(`TPIO_OFS_CH5_IOCTL, {24'h0, `TPIO_IOCTL_RST}, OK);
		rd(`TPIO_OFS_CH0_IOCTL_H, {24'h0, `TPIO_IOCTL_RST}, OK);
		rd(`TPIO_OFS_CH0_IOCTL_L, {24'h0, `TPIO_IOCTL_RST}, OK);
		rd(`TPIO_OFS_CH0_MODE, {24'h0, `TPIO_MODE_RST}, OK);
		for (c = 0; c < 3; c++) rd(gr_of(c), {16'h0, `TPIO_GR_RST}, OK);
		rd(8'h20, 32'h0, ER);
		wr(8'h24, 32'h5, ER);
		wr(`TPIO_OFS_STATUS, 32'h5, ER);
		wr(`TPIO_OFS_CH5_GR_B, 32'h0100, OK);
		for (c = 0; c < 8; c++) begin
			wr(`TPIO_OFS_CH5_IOCTL, fld(0, c[3:0]), OK);
			rd(`TPIO_OFS_CH5_IOCTL, fld(0, c[3:0]), OK);
			repeat (4) @(posedge clk);
			chk_bit("oe", c[1:0] != 2'h0, ch5_pin_b_oe);
			if (c[1:0] != 2'h0) chk_bit("init", c[2], ch5_pin_b_out);
			if (c[1:0] != 2'h0) begin
				hit();
				chk_bit("match1", c[1:0] == 2'h3 ? ~c[2] : c[1], ch5_pin_b_out);
				hit();
				chk_bit("match2", c[1:0] == 2'h3 ? c[2] : c[1], ch5_pin_b_out);
			end
		end
		cap(1, 4'h8, 1'b1, 1'b0);
		cap(1, 4'h9, 1'b0, 1'b1);
		cap(1, 4'ha, 1'b1, 1'b1);
		cap(1, 4'hb, 1'b1, 1'b1);
		cap(1, 4'hc, 1'b0, 1'b0);
		cap(2, 4'h8, 1'b1, 1'b0);
		cap(2, 4'h9, 1'b0, 1'b1);
		cap(2, 4'ha, 1'b1, 1'b1);
		cap(0, 4'hc, 1'b1, 1'b0);
		cap(0, 4'hd, 1'b0, 1'b1);
		cap(0, 4'hf, 1'b1, 1'b1);
		for (c = 1; c < 3; c++) begin
			wr(io_of(c), fld(c, c == 1 ? 4'hc : 4'hf), OK);
			wr(gr_of(c), 32'h0, OK);
			ld(16'h3333);
			tick_up <= 1'b1;
			@(posedge clk);
			tick_up <= 1'b0;
			repeat (3) @(posedge clk);
			rd(gr_of(c), 32'h3333, OK);
			ld(16'h4444);
			tick_dn <= 1'b1;
			@(posedge clk);
			tick_dn <= 1'b0;
			repeat (3) @(posedge clk);
			rd(gr_of(c), 32'h4444, OK);
		end
		wr(`TPIO_OFS_CH0_MODE, 32'h1, OK);
		rd(`TPIO_OFS_CH0_MODE, 32'h1, OK);
		cap(2, 4'h8, 1'b0, 1'b0);
		wr(`TPIO_OFS_CH0_MODE, 32'h0, OK);
		cap(2, 4'h8, 1'b1, 1'b0);
		for (c = 1; c < 3; c++) begin
			wr(gr_of(c), 32'h0100, OK);
			wr(io_of(c), fld(c, 4'h7), OK);
			repeat (4) @(posedge clk);
			chk_bit("oe_ch0", 1'b1, c == 1 ? ch0_pin_a_oe : ch0_pin_c_oe);
			chk_bit("init_ch0", 1'b1, c == 1 ? ch0_pin_a_out : ch0_pin_c_out);
			hit();
			chk_bit("toggle_ch0", 1'b0, c == 1 ? ch0_pin_a_out : ch0_pin_c_out);
		end
		end_of_test();
	end
endmodule : tpio_top_bench
